//--- ssp_pkg.sv
// Package with register map, field positions and timing constants
`default_nettype none
package ssp_pkg;

  // Register indices as printed; byte address is base plus four times index
  localparam logic [11:0] IDX_CORE_INT  = 12'h007;
  localparam logic [11:0] IDX_IRQ_FLAGS = 12'h010;
  localparam logic [11:0] IDX_IRQ_ENS   = 12'h011;
  localparam logic [11:0] IDX_CTRL_ONE  = 12'h011;
  localparam logic [11:0] IDX_STATUS    = 12'h013;
  localparam logic [11:0] IDX_DATA_BUF  = 12'h014;

  // Bank windows and the pin setup register
  localparam logic [11:0] BANK4_BASE    = 12'h100;
  localparam logic [11:0] BANK6_BASE    = 12'h000;
  localparam logic [11:0] ADDR_IRQ_FLAGS = BANK4_BASE + (IDX_IRQ_FLAGS << 2);
  localparam logic [11:0] ADDR_IRQ_ENS   = BANK4_BASE + (IDX_IRQ_ENS << 2);
  localparam logic [11:0] ADDR_CTRL_ONE  = BANK6_BASE + (IDX_CTRL_ONE << 2);
  localparam logic [11:0] ADDR_STATUS    = BANK6_BASE + (IDX_STATUS << 2);
  localparam logic [11:0] ADDR_DATA_BUF  = BANK6_BASE + (IDX_DATA_BUF << 2);
  localparam logic [11:0] ADDR_PIN_SETUP = 12'h200;

  // Control one fields
  localparam int CTRL_WRITE_COLLISION = 7;
  localparam int CTRL_OVF  = 6;
  localparam int CTRL_EN   = 5;
  localparam int CTRL_CKP  = 4;
  localparam int MODE_HI   = 3;
  localparam int MODE_LO   = 0;

  // Status, flag, enable and pin setup fields
  localparam int STAT_SMP  = 7;
  localparam int STAT_CKE  = 6;
  localparam int STAT_BF   = 0;
  localparam int FLAG_PORT = 7;
  localparam int ENA_PORT  = 7;
  localparam int PIN_SDO_IN = 0;
  localparam int PIN_SCK_IN = 1;
  localparam int PIN_SEL_LATCH = 2;

  // Reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h02;
  localparam logic [7:0] ENS_RST   = 8'h00;
  localparam logic [2:0] PIN_RST   = 3'h7;

  // Mode field encodings
  localparam logic [3:0] MODE_MST_DIV4  = 4'h0;
  localparam logic [3:0] MODE_MST_DIV16 = 4'h1;
  localparam logic [3:0] MODE_MST_DIV64 = 4'h2;
  localparam logic [3:0] MODE_MST_TMR2  = 4'h3;
  localparam logic [3:0] MODE_SLV_SEL   = 4'h4;
  localparam logic [3:0] MODE_SLV_FREE  = 4'h5;

  // Bit clock divisions of the core clock, as full periods, and their half periods
  localparam int DIV_FOSC4  = 4;
  localparam int DIV_FOSC16 = 16;
  localparam int DIV_FOSC64 = 64;
  localparam logic [5:0] HALF_DIV4  = 6'(DIV_FOSC4 / 2);
  localparam logic [5:0] HALF_DIV16 = 6'(DIV_FOSC16 / 2);
  localparam logic [5:0] HALF_DIV64 = 6'(DIV_FOSC64 / 2);

  // Last bit index of an eight-bit word
  localparam logic [3:0] LAST_BIT = 4'h7;

  // Master sequencer, Gray coded along idle, lead half, trail half
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_TRAIL = 2'b11
  } ssp_mst_e;

endpackage : ssp_pkg
`default_nettype wire

//--- ssp_sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ssp_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= RST;
      q      <= RST;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : ssp_sync2
`default_nettype wire

//--- ssp_spi_top.sv
// SPI mode of the synchronous serial port with APB register access
//
// How it works
// - Shift register reachable only through data buffer
// - Port works only while enable bit set
// - Opposite pin direction overrides serial function
// - Shift out one edge, capture the other, except master with edge select and sample phase set
// - Master owns clock, may start any time
// - Master buffer write starts eight-bit exchange
// - Master with output as input keeps receiving
// - Master rate: div4, div16, div64, timer/2
// - Most significant bit first
// - Edge select one: data valid before first edge
// - Slave shifts on external clock, flags byte
// - Select gating only in select-controlled slave mode
// - Select low enables shifting and output drive
// - Select high releases output at once
// - Port reset clears bit counter
// - Output pin as input never transmits
// - Master freezes during sleep, then resumes
// - Slave shifts during sleep, flag wakes
// - Device reset disables port, aborts transfer
// - Mode field picks master rate or slave
// - Polarity bit sets clock idle level
// - Buffer write mid-transfer ignored, collision flag
// - Finished byte to buffer except on slave overrun; full and flag set
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ssp_spi_top (
  input  wire logic        REF_CLK,
  input  wire logic        SRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  input  wire logic        SCK_IN,
  input  wire logic        SERIAL_DATA_IN,
  input  wire logic        SS_N,
  input  wire logic        SLEEP,
  input  wire logic        TMR2_TICK,
  output var  logic        SCK_OUT,
  output var  logic        SCK_OE,
  output var  logic        SDO_OUT,
  output var  logic        SDO_OE,
  output var  logic        WAKE
);

  typedef struct packed {
    logic [7:0]       ctrl;
    logic             input_sample_phase;
    logic             cke;
    logic             bf;
    logic [7:0]       flags;
    logic [7:0]       ens;
    logic [2:0]       pins;
    logic [7:0]       rxbuf;
    logic [7:0]       sr;
    logic [3:0]       bitcnt;
    logic [5:0]       half_cnt;
    ssp_pkg::ssp_mst_e st;
    logic             sck_prev;
    logic             sck_out;
    logic             sck_oe;
    logic             sdo_out;
    logic             sdo_oe;
    logic             pready;
    logic             pslverr;
    logic             wake;
    logic [31:0]      prdata;
  } ssp_state_s;

  localparam ssp_state_s RST_STATE = '{
    ctrl:     ssp_pkg::CTRL_RST,
    input_sample_phase:      1'b0,
    cke:      1'b0,
    bf:       1'b0,
    flags:    ssp_pkg::FLAGS_RST,
    ens:      ssp_pkg::ENS_RST,
    pins:     ssp_pkg::PIN_RST,
    rxbuf:    8'h00,
    sr:       8'h00,
    bitcnt:   4'h0,
    half_cnt: 6'h00,
    st:       ssp_pkg::ST_IDLE,
    sck_prev: 1'b0,
    sck_out:  1'b0,
    sck_oe:   1'b0,
    sdo_out:  1'b0,
    sdo_oe:   1'b0,
    pready:   1'b0,
    pslverr:  1'b0,
    wake:     1'b0,
    prdata:   32'h0000_0000
  };

  ssp_state_s s_r;
  ssp_state_s s_nxt;
  logic       sck_s;
  logic       sdi_s;
  logic       ss_n_s;

  // Pin inputs cross into the core clock domain
  ssp_sync2 #(
    .W   (3),
    .RST (3'h4)
  ) u_sync (
    .clk (REF_CLK),
    .rst (SRST),
    .d   ({SS_N, SERIAL_DATA_IN, SCK_IN}),
    .q   ({ss_n_s, sdi_s, sck_s})
  );

  // Mode decode: master encodings
  function automatic logic is_master(input logic [3:0] m);
    is_master = (m == ssp_pkg::MODE_MST_DIV4) ||
                (m == ssp_pkg::MODE_MST_DIV16) ||
                (m == ssp_pkg::MODE_MST_DIV64) ||
                (m == ssp_pkg::MODE_MST_TMR2);
  endfunction : is_master

  // Mode decode: slave encodings
  function automatic logic is_slave(input logic [3:0] m);
    is_slave = (m == ssp_pkg::MODE_SLV_SEL) ||
               (m == ssp_pkg::MODE_SLV_FREE);
  endfunction : is_slave

  // Half period of the master bit clock in core cycles
  function automatic logic [5:0] half_of(input logic [3:0] m);
    if (m == ssp_pkg::MODE_MST_DIV16) begin
      half_of = ssp_pkg::HALF_DIV16;
    end else if (m == ssp_pkg::MODE_MST_DIV64) begin
      half_of = ssp_pkg::HALF_DIV64;
    end else begin
      half_of = ssp_pkg::HALF_DIV4;
    end
  endfunction : half_of

  // Next state of the whole block
  always_comb begin
    logic [3:0] mode;
    logic       en;
    logic       clock_idle_polarity;
    logic       mst;
    logic       slv;
    logic       sel_mode;
    logic       gated;
    logic       setup;
    logic       acc_wr;
    logic       acc_rd;
    logic       buf_wr;
    logic       busy;
    logic       tick;
    logic       sample;
    logic       done;
    logic       cont;
    logic       lead_edge;
    logic       trail_edge;
    logic       hit;
    logic [7:0] rd_val;
    logic [7:0] sr_n;

    s_nxt      = s_r;
    mode       = s_r.ctrl[ssp_pkg::MODE_HI:ssp_pkg::MODE_LO];
    en         = s_r.ctrl[ssp_pkg::CTRL_EN];
    clock_idle_polarity        = s_r.ctrl[ssp_pkg::CTRL_CKP];
    mst        = en && is_master(mode);
    slv        = en && is_slave(mode);
    sel_mode   = slv && (mode == ssp_pkg::MODE_SLV_SEL);
    gated      = sel_mode && ss_n_s;
    setup      = PSEL && PENABLE && !s_r.pready;
    acc_wr     = PSEL && PENABLE && s_r.pready && PWRITE;
    acc_rd     = PSEL && PENABLE && s_r.pready && !PWRITE;
    buf_wr     = acc_wr && (PADDR == ssp_pkg::ADDR_DATA_BUF);
    busy       = mst ? (s_r.st != ssp_pkg::ST_IDLE) : (s_r.bitcnt != 4'h0);
    cont       = mst && s_r.pins[ssp_pkg::PIN_SDO_IN];
    done       = 1'b0;
    sample     = 1'b0;
    sr_n       = s_r.sr;
    lead_edge  = (sck_s != s_r.sck_prev) && (sck_s != clock_idle_polarity);
    trail_edge = (sck_s != s_r.sck_prev) && (sck_s == clock_idle_polarity);
    if (mode == ssp_pkg::MODE_MST_TMR2) begin
      tick = TMR2_TICK;
    end else begin
      tick = (s_r.half_cnt == half_of(mode) - 6'h01);
    end
    s_nxt.sck_prev = sck_s;

    // Register read mux; the shift register has no address of its own
    hit    = 1'b1;
    rd_val = 8'h00;
    if (PADDR == ssp_pkg::ADDR_CTRL_ONE) begin
      rd_val = s_r.ctrl;
    end else if (PADDR == ssp_pkg::ADDR_STATUS) begin
      rd_val[ssp_pkg::STAT_SMP] = s_r.input_sample_phase;
      rd_val[ssp_pkg::STAT_CKE] = s_r.cke;
      rd_val[ssp_pkg::STAT_BF]  = s_r.bf;
    end else if (PADDR == ssp_pkg::ADDR_DATA_BUF) begin
      rd_val = s_r.rxbuf;
    end else if (PADDR == ssp_pkg::ADDR_IRQ_FLAGS) begin
      rd_val = s_r.flags;
    end else if (PADDR == ssp_pkg::ADDR_IRQ_ENS) begin
      rd_val = s_r.ens;
    end else if (PADDR == ssp_pkg::ADDR_PIN_SETUP) begin
      rd_val = {5'h00, s_r.pins};
    end else begin
      hit = 1'b0;
    end

    // APB answer one cycle into the access phase
    s_nxt.pready  = setup;
    s_nxt.pslverr = setup && !hit;
    s_nxt.prdata  = (setup && !PWRITE) ? {24'h00_0000, rd_val} : 32'h0000_0000;

    // Register writes and read side effects
    if (acc_wr && PADDR == ssp_pkg::ADDR_CTRL_ONE) begin
      s_nxt.ctrl = PWDATA[7:0];
    end else if (acc_wr && PADDR == ssp_pkg::ADDR_STATUS) begin
      s_nxt.input_sample_phase = PWDATA[ssp_pkg::STAT_SMP];
      s_nxt.cke = PWDATA[ssp_pkg::STAT_CKE];
    end else if (acc_wr && PADDR == ssp_pkg::ADDR_IRQ_FLAGS) begin
      s_nxt.flags = PWDATA[7:0];
    end else if (acc_wr && PADDR == ssp_pkg::ADDR_IRQ_ENS) begin
      s_nxt.ens = PWDATA[7:0];
    end else if (acc_wr && PADDR == ssp_pkg::ADDR_PIN_SETUP) begin
      s_nxt.pins = PWDATA[2:0];
    end
    if (acc_rd && PADDR == ssp_pkg::ADDR_DATA_BUF) begin
      s_nxt.bf = 1'b0;
    end

    // Buffer write: load the shift register or flag a collision
    if (buf_wr && en) begin
      if (busy || cont) begin
        s_nxt.ctrl[ssp_pkg::CTRL_WRITE_COLLISION] = 1'b1;
      end else begin
        s_nxt.sr = PWDATA[7:0];
        sr_n     = PWDATA[7:0];
        if (s_r.cke) begin
          s_nxt.sdo_out = PWDATA[7];
        end
        if (mst) begin
          s_nxt.st       = ssp_pkg::ST_LEAD;
          s_nxt.half_cnt = 6'h00;
          s_nxt.bitcnt   = 4'h0;
        end
      end
    end

    // Master sequencer, frozen while asleep
    if (mst && s_r.st == ssp_pkg::ST_IDLE && cont) begin
      s_nxt.st       = ssp_pkg::ST_LEAD;
      s_nxt.half_cnt = 6'h00;
      s_nxt.bitcnt   = 4'h0;
    end else if (mst && s_r.st != ssp_pkg::ST_IDLE && !SLEEP) begin
      s_nxt.half_cnt = tick ? 6'h00 : s_r.half_cnt + 6'h01;
      if (tick) begin
        case (s_r.st)
          ssp_pkg::ST_LEAD: begin
            s_nxt.sck_out = !clock_idle_polarity;
            s_nxt.st      = ssp_pkg::ST_TRAIL;
            if (s_r.cke && !s_r.input_sample_phase) begin
              s_nxt.sr = {s_r.sr[6:0], sdi_s};
            end else if (!s_r.cke) begin
              s_nxt.sdo_out = s_r.sr[7];
            end
          end
          ssp_pkg::ST_TRAIL: begin
            s_nxt.sck_out = clock_idle_polarity;
            sample        = !s_r.cke || s_r.input_sample_phase;
            sr_n          = sample ? {s_r.sr[6:0], sdi_s} : s_r.sr;
            s_nxt.sr      = sr_n;
            if (s_r.cke) begin
              s_nxt.sdo_out = sr_n[7];
            end
            s_nxt.bitcnt = s_r.bitcnt + 4'h1;
            s_nxt.st     = ssp_pkg::ST_LEAD;
            if (s_r.bitcnt == ssp_pkg::LAST_BIT) begin
              done         = 1'b1;
              s_nxt.bitcnt = 4'h0;
              s_nxt.st     = cont ? ssp_pkg::ST_LEAD : ssp_pkg::ST_IDLE;
            end
          end
          default: begin
            s_nxt.st = ssp_pkg::ST_IDLE;
          end
        endcase
      end
    end

    // Slave shifter on synchronised clock edges, also during sleep
    if (slv && gated) begin
      s_nxt.bitcnt = 4'h0;
    end else if (slv) begin
      s_nxt.sck_out = clock_idle_polarity;
      if ((lead_edge && s_r.cke) || (trail_edge && !s_r.cke)) begin
        sr_n         = {s_r.sr[6:0], sdi_s};
        s_nxt.sr     = sr_n;
        s_nxt.bitcnt = s_r.bitcnt + 4'h1;
        if (s_r.bitcnt == ssp_pkg::LAST_BIT) begin
          done         = 1'b1;
          s_nxt.bitcnt = 4'h0;
        end
      end else if (lead_edge || trail_edge) begin
        s_nxt.sdo_out = s_r.sr[7];
      end
    end

    // Completed byte: buffer, full flag and port flag
    if (done) begin
      if (slv && s_r.bf) begin
        s_nxt.ctrl[ssp_pkg::CTRL_OVF] = 1'b1;           // byte lost
      end else begin
        s_nxt.rxbuf = sr_n;
        s_nxt.bf    = 1'b1;
      end
      s_nxt.flags[ssp_pkg::FLAG_PORT] = 1'b1;
    end

    // Port disabled: sequencer and counter forced idle
    if (!en) begin
      s_nxt.st       = ssp_pkg::ST_IDLE;
      s_nxt.bitcnt   = 4'h0;
      s_nxt.half_cnt = 6'h00;
    end
    if (!mst || s_r.st == ssp_pkg::ST_IDLE) begin
      if (!slv) begin
        s_nxt.sck_out = clock_idle_polarity;
      end
    end

    // Pin drive, with direction bits overriding the port
    s_nxt.sck_oe = mst && !s_r.pins[ssp_pkg::PIN_SCK_IN];
    s_nxt.sdo_oe = (mst || slv) && !gated &&
                   !s_r.pins[ssp_pkg::PIN_SDO_IN];
    s_nxt.wake   = s_r.flags[ssp_pkg::FLAG_PORT] &&
                   s_r.ens[ssp_pkg::ENA_PORT];
  end

  // State register; synchronous reset disables the port
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      s_r <= RST_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign PRDATA  = s_r.prdata;
  assign PREADY  = s_r.pready;
  assign PSLVERR = s_r.pslverr;
  assign SCK_OUT = s_r.sck_out;
  assign SCK_OE  = s_r.sck_oe;
  assign SDO_OUT = s_r.sdo_out;
  assign SDO_OE  = s_r.sdo_oe;
  assign WAKE    = s_r.wake;

endmodule : ssp_spi_top
`default_nettype wire

//--- ssp_spi_monitor.sv
// Checker of port timing for the serial port block
`timescale 1ns/1ps
`default_nettype none
module ssp_spi_monitor (
  input wire logic        REF_CLK,
  input wire logic        SRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        SS_N,
  input wire logic        SLEEP,
  input wire logic        SCK_OUT,
  input wire logic        SCK_OE,
  input wire logic        SDO_OE,
  input wire logic        WAKE
);
  // All checks on the core clock, idle during reset
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  // Register answer is a single-cycle pulse
  sequence s_pulse;
    PREADY ##1 !PREADY;
  endsequence
  property p_ready;
    PSEL && $rose(PENABLE) |=> s_pulse;
  endproperty
  a_ready: assert property (p_ready) else $error("ready late or long");
  property p_quiet;
    !PSEL |-> !PREADY && PRDATA == '0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("answer while idle");
  property p_err;
    PSLVERR |-> PREADY;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_upper;
    PREADY |-> PRDATA[31:8] == '0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper data bits set");

  // Pins released right after reset; data out released within four cycles of select rising
  property p_rst;
    $fell(SRST) |-> !SCK_OE && !SDO_OE && !WAKE;
  endproperty
  a_rst: assert property (p_rst) else $error("pins driven after reset");
  property p_rel;
    $rose(SS_N) |-> ##[1:4] !SDO_OE;
  endproperty
  a_rel: assert property (p_rel) else $error("data out not released");

  // Clock levels last at least two cycles; sleep freezes the clock
  property p_half;
    SCK_OE && $changed(SCK_OUT) |=> $stable(SCK_OUT);
  endproperty
  a_half: assert property (p_half) else $error("clock level too short");
  property p_sleep;
    SLEEP [*2] ##0 SCK_OE |=> $stable(SCK_OUT);
  endproperty
  a_sleep: assert property (p_sleep) else $error("clock runs in sleep");

  // Wake request only drops within three cycles of a register answer
  property p_wake;
    $fell(WAKE) |-> $past(PREADY) || $past(PREADY, 2) || $past(PREADY, 3);
  endproperty
  a_wake: assert property (p_wake) else $error("wake dropped alone");
endmodule : ssp_spi_monitor

bind ssp_spi_top ssp_spi_monitor mon (.REF_CLK, .SRST, .PSEL, .PENABLE,
  .PRDATA, .PREADY, .PSLVERR, .SS_N, .SLEEP, .SCK_OUT, .SCK_OE, .SDO_OE,
  .WAKE);
`default_nettype wire

//--- ssp_spi_peer.sv
// Far-side SPI controller model, slave or master role
`timescale 1ns/1ps
`default_nettype none
module ssp_spi_peer (
  input  wire logic sck_i,
  input  wire logic sdo_i,
  output var  logic sck_o,
  output var  logic ss_n_o,
  output var  logic sdi_o
);
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic       slv_on;

  // Idle link: clock at rest low, select high
  initial begin
    sck_o = 1'b0;
    ss_n_o = 1'b1;
    sdi_o = 1'b0;
    slv_on = 1'b0;
    tx_r = 8'h00;
    rx_r = 8'h00;
  end

  // Slave role samples on the leading edge, MSB first
  always @(posedge sck_i) if (slv_on) rx_r = {rx_r[6:0], sdo_i};

  // Slave role moves on at the trailing edge; the inverted low bit fills in behind
  always @(negedge sck_i) if (slv_on) begin
    tx_r = {tx_r[6:0], ~tx_r[0]};
    sdi_o = tx_r[7];
  end

  // Arms the slave role with its first bit already on the line
  task automatic load(input logic [7:0] b);
    tx_r = b;
    sdi_o = b[7];
    rx_r = 8'h00;
    slv_on = 1'b1;
  endtask : load

  // Master role: one framed byte, 40 ns per clock level, off core phase
  task automatic xfer(input logic [7:0] b);
    slv_on = 1'b0;
    tx_r = b;
    sdi_o = b[7];
    #43.3 ss_n_o = 1'b0;
    #80;
    repeat (8) begin
      sck_o = 1'b1;
      rx_r = {rx_r[6:0], sdo_i};
      #40 sck_o = 1'b0;
      tx_r = {tx_r[6:0], ~tx_r[0]};
      sdi_o = tx_r[7];
      #40;
    end
    ss_n_o = 1'b1;
    sdi_o = ~sdi_o;
  endtask : xfer
endmodule : ssp_spi_peer
`default_nettype wire

//--- ssp_spi_top_tb.sv
// Self-checking bench for the serial port block
`timescale 1ns/1ps
`default_nettype none
module ssp_spi_top_tb;
  logic        ref_clk;
  logic        srst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sleep;
  logic        tmr2_tick = 1'b0;
  logic        sck_out;
  logic        sck_oe;
  logic        sdo_out;
  logic        sdo_oe;
  logic        wake;
  wire logic   sck_in;
  wire logic   serial_data_in;
  wire logic   ss_n;
  int          mismatches;
  int          total_checks;
  int          tcnt = 0;
  int          half [4] = '{ssp_pkg::DIV_FOSC4 / 2, ssp_pkg::DIV_FOSC16 / 2,
                            ssp_pkg::DIV_FOSC64 / 2, 10};

  ssp_spi_top dut (.REF_CLK(ref_clk), .SRST(srst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SCK_IN(sck_in),
    .SERIAL_DATA_IN(serial_data_in), .SS_N(ss_n), .SLEEP(sleep), .TMR2_TICK(tmr2_tick),
    .SCK_OUT(sck_out), .SCK_OE(sck_oe), .SDO_OUT(sdo_out), .SDO_OE(sdo_oe),
    .WAKE(wake));
  ssp_spi_peer peer (.sck_i(sck_out), .sdo_i(sdo_out), .sck_o(sck_in),
    .ss_n_o(ss_n), .sdi_o(serial_data_in));

  // Core clock, 5 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Timer tick every 10 core cycles
  always @(posedge ref_clk) begin
    tcnt <= (tcnt == 9) ? 0 : tcnt + 1;
    tmr2_tick <= (tcnt == 0);
  end

  task automatic test_done;
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic guard(input int n);
    if (n >= 2000) begin
      mismatches++;
      test_done();
    end
  endtask : guard

  // One APB transfer, waiting for the ready answer
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'(d);
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 2000);
    guard(n);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rc(input logic [11:0] a, input logic [7:0] x,
                    input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 8'h00, r, e);
    chk($sformatf("reg %h", a), 32'(x), r);
    chk($sformatf("err %h", a), 32'(xe), 32'(e));
  endtask : rc

  // Poll status until the buffer holds a byte
  task automatic wait_bf;
    int          n;
    logic [31:0] r;
    logic        e;
    n = 0;
    r = '0;
    while (r[0] !== 1'b1 && n < 2000) begin
      apb(1'b0, ssp_pkg::ADDR_STATUS, 8'h00, r, e);
      n++;
    end
    guard(n);
  endtask : wait_bf

  // Cycles until the serial clock output changes
  task automatic till_chg(output int n);
    logic p;
    n = 0;
    p = sck_out;
    while (sck_out === p && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    guard(n);
  endtask : till_chg

  initial begin
    logic [31:0] r;
    logic        e;
    int          n;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    sleep = 1'b0;
    mismatches = 0;
    total_checks = 0;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    // Reset values and an unmapped word
    rc(ssp_pkg::ADDR_CTRL_ONE, ssp_pkg::CTRL_RST, 1'b0);
    rc(ssp_pkg::ADDR_STATUS, 8'h00, 1'b0);
    rc(ssp_pkg::ADDR_IRQ_FLAGS, ssp_pkg::FLAGS_RST, 1'b0);
    rc(ssp_pkg::ADDR_IRQ_ENS, ssp_pkg::ENS_RST, 1'b0);
    rc(ssp_pkg::ADDR_PIN_SETUP, 8'h07, 1'b0);
    rc(12'h01C, 8'h00, 1'b1);
    // Master at every rate, edge select one
    wr(ssp_pkg::ADDR_PIN_SETUP, 8'h04);
    wr(ssp_pkg::ADDR_IRQ_ENS, 8'h80);
    wr(ssp_pkg::ADDR_STATUS, 8'h40);
    for (int m = 0; m < 4; m++) begin
      wr(ssp_pkg::ADDR_CTRL_ONE, 8'h00);
      wr(ssp_pkg::ADDR_CTRL_ONE, 8'h20 | 8'(m));
      wr(ssp_pkg::ADDR_DATA_BUF, 8'h00);
      till_chg(n);
      till_chg(n);
      chk("sck half", 32'(half[m]), 32'(n));
      wait_bf();
      rc(ssp_pkg::ADDR_DATA_BUF, 8'h00, 1'b0);
    end
    // Master exchange with collision and sleep in mid-byte
    wr(ssp_pkg::ADDR_CTRL_ONE, 8'h00);
    wr(ssp_pkg::ADDR_CTRL_ONE, 8'h21);
    peer.load(8'h3C);
    wr(ssp_pkg::ADDR_DATA_BUF, 8'hA5);
    wr(ssp_pkg::ADDR_DATA_BUF, 8'h11);
    repeat (20) @(posedge ref_clk);
    sleep <= 1'b1;
    repeat (40) @(posedge ref_clk);
    sleep <= 1'b0;
    wait_bf();
    rc(ssp_pkg::ADDR_DATA_BUF, 8'h3C, 1'b0);
    chk("peer rx", 32'h0000_00A5, 32'(peer.rx_r));
    rc(ssp_pkg::ADDR_STATUS, 8'h40, 1'b0);
    rc(ssp_pkg::ADDR_CTRL_ONE, 8'hA1, 1'b0);
    rc(ssp_pkg::ADDR_IRQ_FLAGS, 8'h82, 1'b0);
    chk("wake", 32'h0000_0001, 32'(wake));
    // Master with data out as input keeps receiving
    wr(ssp_pkg::ADDR_CTRL_ONE, 8'h00);
    wr(ssp_pkg::ADDR_PIN_SETUP, 8'h05);
    wr(ssp_pkg::ADDR_CTRL_ONE, 8'h21);
    wait_bf();
    chk("sdo_oe", 32'h0000_0000, 32'(sdo_oe));
    wr(ssp_pkg::ADDR_CTRL_ONE, 8'h00);
    apb(1'b0, ssp_pkg::ADDR_DATA_BUF, 8'h00, r, e);
    // Selected slave, edge select one, asleep
    wr(ssp_pkg::ADDR_PIN_SETUP, 8'h06);
    wr(ssp_pkg::ADDR_IRQ_FLAGS, 8'h02);
    wr(ssp_pkg::ADDR_CTRL_ONE, 8'h24);
    wr(ssp_pkg::ADDR_DATA_BUF, 8'h96);
    sleep <= 1'b1;
    fork
      peer.xfer(8'h5A);
      begin
        #300;
        chk("sdo_oe", 32'h0000_0001, 32'(sdo_oe));
      end
    join
    repeat (10) @(posedge ref_clk);
    chk("wake", 32'h0000_0001, 32'(wake));
    chk("sdo_oe", 32'h0000_0000, 32'(sdo_oe));
    sleep <= 1'b0;
    rc(ssp_pkg::ADDR_DATA_BUF, 8'h5A, 1'b0);
    chk("peer rx", 32'h0000_0096, 32'(peer.rx_r));
    // Reset in mid-run returns the port to its idle state
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    rc(ssp_pkg::ADDR_CTRL_ONE, ssp_pkg::CTRL_RST, 1'b0);
    rc(ssp_pkg::ADDR_STATUS, 8'h00, 1'b0);
    chk("sck_oe", 32'h0000_0000, 32'(sck_oe));
    chk("sdo_oe", 32'h0000_0000, 32'(sdo_oe));
    test_done();
  end
endmodule : ssp_spi_top_tb
`default_nettype wire
